/* File: hdl/rfam_monitor.v */
// Fault latch, alarm flags, interrupt and drive-state logic of the regulator
// Functional notes
// - Thermistor below half bias sets thermal warning
// - Thermistor pullup off in shutdown
// - Sample phase-1 overcurrent before each on-time
// - Unmasked overcurrent drives interrupt active
// - Target above maximum code sets violation flag
// - Effective target clamped to maximum code
// - Open on-time input: tristate, skip low, latch
// - Open on-time fault has no status flag
// - Latch clears only by enable toggle or power
// - Overvoltage over tracking or fixed threshold
// - Skip mode: tracking only once regulating
// - Overvoltage: drives tristate, skip output high
// - Overvoltage ignored while enable low
// - Serial interface keeps working during faults
// - Restart and clear flags once fault gone and enable toggled
// - Qualified undervoltage: shutdown, discharge, latch
// - Undervoltage: drives tristate, skip output low
// - Over-temperature sets latch, tristates drives
// - Thermal restart only after hysteresis cooling
// - Phase-2 sense tied high: single phase
// - Skip high in transitions, floating in shutdown
// - Fixed serial address 70h, fast rates
// - Mask gates interrupt only, not flags
// - D0 set on any unmasked event
// - Interrupt blanked in transitions, 4us release
`include "rfam_consts.vh"
module rfam_monitor #(
  parameter UV_QUAL_CYCLES =
    (`RFAM_UV_QUAL_NS + `RFAM_CLK_PERIOD_NS - 1) / `RFAM_CLK_PERIOD_NS
) (
  input wire i_clock,
  input wire i_rstn,
  input wire i_enable,
  input wire i_thermistor_input_below_half,
  input wire i_phase1_oc_cmp,
  input wire i_ton_open,
  input wire i_ov_track_cmp,
  input wire i_ov_fixed_cmp,
  input wire i_uv_cmp,
  input wire i_tj_hot,
  input wire i_phase2_tied_bias,
  input wire i_phase1_on_start,
  input wire i_transition,
  input wire i_in_regulation,
  input wire i_skip_mode,
  input wire i_target_wr,
  input wire [6:0] i_target_code,
  input wire [7:0] i_max_code,
  input wire [7:0] i_mask,
  input wire i_scl,
  input wire i_sda,
  output wire o_sda,
  output wire o_sda_oe,
  output wire o_int_n,
  output wire o_int_oe,
  output reg [7:0] o_status,
  output reg o_fault_latch,
  output reg [6:0] o_effective_code,
  output wire [1:0] o_phase_drive_oe,
  output wire o_skip_control_out,
  output wire o_skip_control_oe,
  output wire o_thermistor_input_pullup_en,
  output reg o_discharge_en,
  output wire o_single_phase,
  output wire o_run
);
  localparam BLANK_CYCLES = (`RFAM_INT_RELEASE_NS +
    `RFAM_CLK_PERIOD_NS - 1) / `RFAM_CLK_PERIOD_NS;
  localparam NIN = 11;
  // Bus pins start at their idle high level, so no false edge after reset
  localparam [NIN-1:0] SYNC_IDLE = 11'h600;
  localparam [1:0] C_NONE = 2'h0;
  localparam [1:0] C_OV = 2'h1;
  localparam [1:0] C_LOW = 2'h2;
  localparam [1:0] C_THERMISTOR_INPUT = 2'h3;
  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_ADDR = 3'h1;
  localparam [2:0] S_ACK = 3'h2;
  localparam [2:0] S_SEND = 3'h3;
  localparam [2:0] S_MACK = 3'h4;

  // Two-stage synchronisers; stage one is read only by stage two
  reg [NIN-1:0] sync1;
  reg [NIN-1:0] sync2;
  wire [NIN-1:0] raw_in = {i_sda, i_scl, i_enable, i_phase2_tied_bias,
    i_tj_hot, i_uv_cmp, i_ov_fixed_cmp, i_ov_track_cmp, i_ton_open,
    i_phase1_oc_cmp, i_thermistor_input_below_half};
  always @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      sync1 <= SYNC_IDLE;
      sync2 <= SYNC_IDLE;
    end else begin
      sync1 <= raw_in;
      sync2 <= sync1;
    end
  end
  wire thermistor_input_s = sync2[0];
  wire oc_s = sync2[1];
  wire ton_s = sync2[2];
  wire ovt_s = sync2[3];
  wire ovf_s = sync2[4];
  wire uv_s = sync2[5];
  wire hot_s = sync2[6];
  wire p2tied_s = sync2[7];
  wire en_s = sync2[8];
  wire scl_s = sync2[9];
  wire sda_s = sync2[10];

  reg en_q;
  wire en_fall = en_q & ~en_s;
  // Tracking threshold unless skipping and not yet regulating
  wire ov_hit = en_s &
    ((i_skip_mode & ~i_in_regulation) ? ovf_s : ovt_s);
  reg [13:0] uv_cnt;
  wire uv_fault = uv_s && (uv_cnt >= UV_QUAL_CYCLES - 1);
  reg [1:0] cause;
  reg [6:0] target;
  reg [7:0] blank_cnt;
  reg in_trans_q;
  reg oc_rd_clr;

  function [6:0] rfam_clamp;
    input [6:0] req;
    input [6:0] lim;
    begin
      rfam_clamp = (req > lim) ? lim : req;
    end
  endfunction

  // Fault latch; only enable falling edge or power-on reset clears it
  always @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      en_q <= 1'b0;
      o_fault_latch <= 1'b0;
      cause <= C_NONE;
      o_discharge_en <= 1'b0;
      uv_cnt <= 14'h0000;
    end else begin
      en_q <= en_s;
      if (uv_s && o_run && !uv_fault)
        uv_cnt <= uv_cnt + 14'h0001;
      else if (!uv_s || !o_run)
        uv_cnt <= 14'h0000;
      if (!o_fault_latch && ov_hit) begin
        o_fault_latch <= 1'b1;
        cause <= C_OV;
      end else if (!o_fault_latch && en_s && (ton_s || uv_fault)) begin
        o_fault_latch <= 1'b1;
        cause <= C_LOW;
        o_discharge_en <= uv_fault;
      end else if (!o_fault_latch && hot_s) begin
        o_fault_latch <= 1'b1;
        cause <= C_THERMISTOR_INPUT;
      end else if (en_fall) begin
        o_fault_latch <= 1'b0;
        cause <= C_NONE;
        o_discharge_en <= 1'b0;
      end
    end
  end

  // Restart waits for latch clear, cooling hysteresis and conditions gone
  assign o_run = en_s & ~o_fault_latch & ~hot_s & ~ton_s;
  assign o_single_phase = p2tied_s;
  assign o_phase_drive_oe = {o_run & ~p2tied_s,
    o_run};
  assign o_thermistor_input_pullup_en = o_run;
  // Skip output: forced high on overvoltage, low on open/undervoltage
  assign o_skip_control_oe = (cause == C_OV) | (cause == C_LOW) |
    o_run;
  assign o_skip_control_out = (cause == C_OV) ? 1'b1 :
    (cause == C_LOW) ? 1'b0 :
    (i_transition | ~i_skip_mode);

  // Target register and clamp; bit 7 of the limit is ignored
  always @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      target <= `RFAM_CODE_RST;
      o_effective_code <= `RFAM_CODE_RST;
    end else begin
      if (i_target_wr)
        target <= i_target_code;
      o_effective_code <= rfam_clamp(i_target_wr ? i_target_code : target,
        i_max_code[6:0]);
    end
  end

  // Interrupt blanking through the transition and 4us after it ends
  always @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      blank_cnt <= 8'h00;
      in_trans_q <= 1'b0;
    end else begin
      in_trans_q <= i_transition;
      if (i_transition)
        blank_cnt <= BLANK_CYCLES[7:0];
      else if (blank_cnt != 8'h00)
        blank_cnt <= blank_cnt - 8'h01;
    end
  end
  wire int_blank = i_transition | in_trans_q | (blank_cnt != 8'h00);

  // Status flags; the mask reaches only the summary bit 0, and a set beats a clear
  wire [5:1] live_ev = o_status[5:1] & ~i_mask[5:1];
  always @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      o_status <= `RFAM_STATUS_RST;
    end else begin
      o_status[7:6] <= 2'b00;
      o_status[`RFAM_ST_THERMAL] <= thermistor_input_s;
      if (i_phase1_on_start && oc_s)
        o_status[`RFAM_ST_OVERC] <= 1'b1;
      else if (oc_rd_clr)
        o_status[`RFAM_ST_OVERC] <= 1'b0;
      if (i_target_wr)
        o_status[`RFAM_ST_CODE] <=
          (i_target_code > i_max_code[6:0]);
      if (ov_hit)
        o_status[`RFAM_ST_OVERV] <= 1'b1;
      else if (!o_fault_latch)
        o_status[`RFAM_ST_OVERV] <= 1'b0;
      if (uv_fault)
        o_status[`RFAM_ST_UNDERV] <= 1'b1;
      else if (!o_fault_latch && !uv_s)
        o_status[`RFAM_ST_UNDERV] <= 1'b0;
      o_status[`RFAM_ST_INT] <= |live_ev;
    end
  end
  // Open-drain, active low; ton open shows only through the latch
  assign o_int_n = 1'b0;
  assign o_int_oe = (o_status[`RFAM_ST_INT] |
    o_fault_latch) & ~int_blank;

  // Read-only serial slave returning the status byte.
  // Never gated by the fault latch so software can find the cause.
  // Writes get no acknowledge beyond the address byte.
  reg scl_q;
  reg sda_q;
  reg [2:0] st;
  reg [3:0] bcnt;
  reg [7:0] sh;
  reg sda_drv;
  wire scl_rise = scl_s & ~scl_q;
  wire scl_fall = ~scl_s & scl_q;
  wire start_c = scl_s & scl_q & sda_q & ~sda_s;
  wire stop_c = scl_s & scl_q & ~sda_q & sda_s;
  always @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      st <= S_IDLE;
      bcnt <= 4'h0;
      sh <= 8'h00;
      sda_drv <= 1'b0;
      oc_rd_clr <= 1'b0;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
      oc_rd_clr <= 1'b0;
      if (start_c) begin
        st <= S_ADDR;
        bcnt <= 4'h0;
        sda_drv <= 1'b0;
      end else if (stop_c) begin
        st <= S_IDLE;
        sda_drv <= 1'b0;
      end else begin
        case (st)
          S_ADDR: begin
            if (scl_rise) begin
              sh <= {sh[6:0], sda_s};
              bcnt <= bcnt + 4'h1;
            end else if (scl_fall && bcnt == 4'h8) begin
              if (sh[7:1] == `RFAM_I2C_ADDR) begin
                st <= S_ACK;
                sda_drv <= 1'b1;
              end else begin
                st <= S_IDLE;
              end
            end
          end
          S_ACK: begin
            if (scl_fall) begin
              bcnt <= 4'h0;
              if (sh[0]) begin
                st <= S_SEND;
                sh <= {o_status[6:0], 1'b0};
                sda_drv <= ~o_status[7];
              end else begin
                st <= S_IDLE;
                sda_drv <= 1'b0;
              end
            end
          end
          S_SEND: begin
            if (scl_fall) begin
              bcnt <= bcnt + 4'h1;
              if (bcnt == 4'h7) begin
                st <= S_MACK;
                sda_drv <= 1'b0;
                oc_rd_clr <= 1'b1;
              end else begin
                sda_drv <= ~sh[7];
                sh <= {sh[6:0], 1'b0};
              end
            end
          end
          S_MACK: begin
            if (scl_rise) begin
              st <= sda_s ? S_IDLE : S_ACK;
              sh[0] <= 1'b1;
            end
          end
          default: begin
            st <= S_IDLE;
            sda_drv <= 1'b0;
          end
        endcase
      end
    end
  end
  assign o_sda = 1'b0;
  assign o_sda_oe = sda_drv;
endmodule // rfam_monitor

/* File: hdl/rfam_consts.vh */
// Constants for the regulator fault and alarm monitor
`ifndef RFAM_CONSTS_VH
`define RFAM_CONSTS_VH
`define RFAM_CLK_PERIOD_NS 25
`define RFAM_INT_RELEASE_NS 4000
`define RFAM_UV_QUAL_NS 200000
`define RFAM_I2C_ADDR 7'h70
`define RFAM_ST_THERMAL 5
`define RFAM_ST_UNDERV 4
`define RFAM_ST_OVERV 3
`define RFAM_ST_OVERC 2
`define RFAM_ST_CODE 1
`define RFAM_ST_INT 0
`define RFAM_STATUS_RST 8'h00
`define RFAM_CODE_RST 7'h33
`endif

/* File: tb/rfam_monitor_checker.sv */
// Port-level checker of the fault and alarm monitor
module rfam_monitor_checker (
  input wire i_clock,
  input wire i_rstn,
  input wire i_enable,
  input wire i_thermistor_input_below_half,
  input wire i_transition,
  input wire i_skip_mode,
  input wire i_target_wr,
  input wire [6:0] i_target_code,
  input wire [7:0] i_max_code,
  input wire [7:0] i_mask,
  input wire [7:0] o_status,
  input wire o_fault_latch,
  input wire [6:0] o_effective_code,
  input wire [1:0] o_phase_drive_oe,
  input wire o_skip_control_out,
  input wire o_skip_control_oe,
  input wire o_thermistor_input_pullup_en,
  input wire o_single_phase,
  input wire o_run,
  input wire o_int_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rstn);
  AST_TRISTATE:
    assert property (o_fault_latch |-> o_phase_drive_oe == 2'b00)
    else $error("phase drive enabled while latched");
  AST_SKIP_RUN:
    assert property (o_run |-> o_skip_control_oe &&
      o_skip_control_out == (i_transition || !i_skip_mode))
    else $error("skip control wrong while running");
  AST_PULLUP:
    assert property (o_thermistor_input_pullup_en == o_run)
    else $error("thermistor pullup not following run");
  AST_CLAMP:
    assert property (i_target_wr |=> o_effective_code ==
      ($past(i_target_code) > $past(i_max_code[6:0]) ?
      $past(i_max_code[6:0]) : $past(i_target_code)))
    else $error("effective code not clamped");
  AST_CODE_FLAG:
    assert property (i_target_wr |=> o_status[1] ==
      ($past(i_target_code) > $past(i_max_code[6:0])))
    else $error("code violation flag wrong");
  AST_SUMMARY:
    assert property (o_status[0] == $past(|(o_status[5:1] & ~i_mask[5:1])))
    else $error("summary bit wrong");
  AST_BLANK:
    assert property (i_transition |-> !o_int_oe)
    else $error("interrupt not blanked in transition");
  AST_LATCH_HOLD:
    assert property ((o_fault_latch && i_enable)[*4] |=> o_fault_latch)
    else $error("fault latch cleared without enable toggle");
  AST_THERMAL:
    assert property (o_status[5] == $past(i_thermistor_input_below_half, 3))
    else $error("thermal flag timing wrong");
  AST_SINGLE:
    assert property (o_single_phase |-> !o_phase_drive_oe[1])
    else $error("second phase driven in single phase");
endmodule // rfam_monitor_checker

bind rfam_monitor rfam_monitor_checker u_chk (
  .i_clock(i_clock),
  .i_rstn(i_rstn),
  .i_enable(i_enable),
  .i_thermistor_input_below_half(i_thermistor_input_below_half),
  .i_transition(i_transition),
  .i_skip_mode(i_skip_mode),
  .i_target_wr(i_target_wr),
  .i_target_code(i_target_code),
  .i_max_code(i_max_code),
  .i_mask(i_mask),
  .o_status(o_status),
  .o_fault_latch(o_fault_latch),
  .o_effective_code(o_effective_code),
  .o_phase_drive_oe(o_phase_drive_oe),
  .o_skip_control_out(o_skip_control_out),
  .o_skip_control_oe(o_skip_control_oe),
  .o_thermistor_input_pullup_en(o_thermistor_input_pullup_en),
  .o_single_phase(o_single_phase),
  .o_run(o_run),
  .o_int_oe(o_int_oe)
);

/* File: tb/rfam_host.sv */
// Host serial controller model that reads the status byte
module rfam_host (
  output logic o_scl,
  output logic o_sda_oe,
  input wire logic i_sda
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    o_scl = 1;
    o_sda_oe = 0;
  end
  // 200 ns bit slot; clock stays high between frames
  task automatic slot(input logic b, output logic r);
    o_sda_oe = !b;
    #50 o_scl = 1;
    #50 r = i_sda;
    #50 o_scl = 0;
    #50;
  endtask
  task automatic rd(input logic [6:0] a, output logic ack,
                    output logic [7:0] d);
    logic r;
    logic [7:0] f;
    f = {a, 1'b1};
    o_sda_oe = 1;
    #100 o_scl = 0;
    #50;
    for (int i = 7; i >= 0; i--) slot(f[i], r);
    slot(1'b1, r);
    ack = !r;
    for (int i = 7; i >= 0; i--) slot(1'b1, d[i]);
    // Not acknowledging ends the read after one byte
    slot(1'b1, r);
    o_sda_oe = 1;
    #50 o_scl = 1;
    #50 o_sda_oe = 0;
    #100;
  endtask
endmodule // rfam_host

/* File: tb/tb_rfam_monitor.sv */
// Self-checking bench of the regulator fault and alarm monitor
module tb_rfam_monitor;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int UVQ = 20;
  logic i_clock = 0, i_rstn = 0, i_enable = 0, i_thermistor_input_below_half = 0;
  logic i_phase1_oc_cmp = 0, i_ton_open = 0, i_ov_track_cmp = 0;
  logic i_ov_fixed_cmp = 0, i_uv_cmp = 0, i_tj_hot = 0, i_scl;
  logic i_phase2_tied_bias = 0, i_phase1_on_start = 0, i_transition = 0;
  logic i_in_regulation = 0, i_skip_mode = 0, i_target_wr = 0;
  logic [6:0] i_target_code = 7'h00, o_effective_code;
  logic [7:0] i_max_code = 8'h7f, i_mask = 8'h00, o_status, rd;
  logic o_sda, o_sda_oe, o_int_n, o_int_oe, o_fault_latch;
  logic o_skip_control_out, o_skip_control_oe, o_thermistor_input_pullup_en;
  logic o_discharge_en, o_single_phase, o_run, host_oe, ack;
  logic [1:0] o_phase_drive_oe;
  logic [7:0] sk[4] = '{8'h03, 8'h02, 8'h02, 8'h00};
  logic [7:0] st[4] = '{8'h09, 8'h11, 8'h00, 8'h00};
  int n_mismatch = 0, num_checks = 0;
  // Pull-up wins unless someone pulls low
  wire i_sda = !host_oe && (o_sda_oe ? o_sda : 1'b1);
  // Interrupt pin as the external pull-up sees it
  wire int_pin = o_int_oe ? o_int_n : 1'b1;
  rfam_monitor #(.UV_QUAL_CYCLES(UVQ)) u_dut (
    .i_clock(i_clock),
    .i_rstn(i_rstn),
    .i_enable(i_enable),
    .i_thermistor_input_below_half(i_thermistor_input_below_half),
    .i_phase1_oc_cmp(i_phase1_oc_cmp),
    .i_ton_open(i_ton_open),
    .i_ov_track_cmp(i_ov_track_cmp),
    .i_ov_fixed_cmp(i_ov_fixed_cmp),
    .i_uv_cmp(i_uv_cmp),
    .i_tj_hot(i_tj_hot),
    .i_phase2_tied_bias(i_phase2_tied_bias),
    .i_phase1_on_start(i_phase1_on_start),
    .i_transition(i_transition),
    .i_in_regulation(i_in_regulation),
    .i_skip_mode(i_skip_mode),
    .i_target_wr(i_target_wr),
    .i_target_code(i_target_code),
    .i_max_code(i_max_code),
    .i_mask(i_mask),
    .i_scl(i_scl),
    .i_sda(i_sda),
    .o_sda(o_sda),
    .o_sda_oe(o_sda_oe),
    .o_int_n(o_int_n),
    .o_int_oe(o_int_oe),
    .o_status(o_status),
    .o_fault_latch(o_fault_latch),
    .o_effective_code(o_effective_code),
    .o_phase_drive_oe(o_phase_drive_oe),
    .o_skip_control_out(o_skip_control_out),
    .o_skip_control_oe(o_skip_control_oe),
    .o_thermistor_input_pullup_en(o_thermistor_input_pullup_en),
    .o_discharge_en(o_discharge_en),
    .o_single_phase(o_single_phase),
    .o_run(o_run)
  );
  rfam_host u_host (.o_scl(i_scl), .o_sda_oe(host_oe), .i_sda(i_sda));
  always #12.5 i_clock = !i_clock;
  task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic step(int n);
    repeat (n) @(posedge i_clock);
    #2;
  endtask
  task automatic wr(logic [6:0] c);
    i_target_code = c;
    i_target_wr = 1;
    step(1);
    i_target_wr = 0;
    step(3);
  endtask
  task automatic close_out;
    if (n_mismatch == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #500000;
    n_mismatch++;
    close_out;
  end
  initial begin
    step(16);
    i_rstn = 1;
    chk("status", o_status, 8'h00);
    chk("code", 8'(o_effective_code), 8'h33);
    // Both comparators high with enable low, so neither one may trip the latch
    {i_ov_fixed_cmp, i_ov_track_cmp} = 2'b11;
    step(10);
    chk("idle", 8'({o_fault_latch, o_skip_control_oe, o_thermistor_input_pullup_en}),
        8'h00);
    {i_ov_fixed_cmp, i_ov_track_cmp} = 2'b00;
    i_enable = 1;
    step(6);
    chk("run", 8'({o_run, o_thermistor_input_pullup_en}), 8'h03);
    i_max_code = 8'h30;
    wr(7'h40);
    chk("clamp", 8'(o_effective_code), 8'h30);
    chk("status", o_status, 8'h03);
    chk("int", 8'(o_int_oe), 8'h01);
    i_mask = 8'h02;
    step(3);
    chk("masked", o_status, 8'h02);
    chk("int", 8'(o_int_oe), 8'h00);
    i_mask = 8'h00;
    i_transition = 1;
    step(3);
    chk("blank", 8'(o_int_oe), 8'h00);
    i_transition = 0;
    step(150);
    chk("blank", 8'(o_int_oe), 8'h00);
    step(20);
    chk("release", 8'(o_int_oe), 8'h01);
    wr(7'h20);
    chk("code", 8'(o_effective_code), 8'h20);
    chk("status", o_status, 8'h00);
    i_thermistor_input_below_half = 1;
    step(4);
    chk("thermal", o_status, 8'h21);
    i_thermistor_input_below_half = 0;
    i_phase1_oc_cmp = 1;
    step(5);
    i_phase1_on_start = 1;
    step(1);
    i_phase1_on_start = 0;
    i_phase1_oc_cmp = 0;
    step(3);
    chk("oc", o_status, 8'h05);
    chk("int", 8'(o_int_oe), 8'h01);
    chk("int_pin", 8'(int_pin), 8'h00);
    u_host.rd(7'h70, ack, rd);
    chk("ack", 8'(ack), 8'h01);
    chk("read", rd, 8'h05);
    u_host.rd(7'h71, ack, rd);
    chk("ack", 8'(ack), 8'h00);
    i_skip_mode = 1;
    i_ov_track_cmp = 1;
    step(10);
    chk("track", 8'(o_fault_latch), 8'h00);
    i_in_regulation = 1;
    step(5);
    chk("track", 8'(o_fault_latch), 8'h01);
    {i_ov_track_cmp, i_in_regulation} = 2'b00;
    i_enable = 0;
    step(5);
    i_enable = 1;
    step(10);
    for (int k = 0; k < 4; k++) begin
      {i_tj_hot, i_ton_open, i_uv_cmp, i_ov_fixed_cmp} = 4'b1 << k;
      step(UVQ + 10);
      chk("latch", 8'({o_fault_latch, o_phase_drive_oe}),
          8'h04);
      chk("skip", 8'({o_skip_control_oe, o_skip_control_oe &
          o_skip_control_out}), sk[k]);
      chk("flag", o_status, st[k]);
      if (k == 0) begin
        u_host.rd(7'h70, ack, rd);
        chk("read", rd, 8'h09);
      end
      if (k == 1)
        chk("discharge", 8'(o_discharge_en), 8'h01);
      {i_tj_hot, i_ton_open, i_uv_cmp, i_ov_fixed_cmp} = 4'b0;
      step(5);
      chk("hold", 8'(o_fault_latch), 8'h01);
      i_enable = 0;
      step(5);
      i_enable = 1;
      step(10);
      chk("restart", 8'({o_fault_latch, o_run}), 8'h01);
      chk("cleared", o_status, 8'h00);
    end
    i_phase2_tied_bias = 1;
    step(5);
    chk("phase2", 8'({o_single_phase, o_phase_drive_oe[1]}),
        8'h02);
    // Power cycle is the other way to clear the latch
    i_ton_open = 1;
    step(5);
    chk("pre_por", 8'(o_fault_latch), 8'h01);
    i_ton_open = 0;
    i_rstn = 0;
    step(2);
    chk("por", 8'({o_fault_latch, o_status[0]}), 8'h00);
    i_rstn = 1;
    step(5);
    chk("after_por", 8'({o_fault_latch, o_run}), 8'h01);
    close_out;
  end
endmodule // tb_rfam_monitor
